// ### rtl/lsec_ctrl.sv
`timescale 1ns/10ps
`include "lsec_map.svh"

// Contract
// - Switch bit 0 runs the oscillator; timers and converters stop without it.
// - Switch bit 1 turns ambient light measurement on or off.
// - Switch bit 4 lets filtered light interrupts reach the pin.
// - Switch bit 7 lets unfiltered threshold interrupts reach the pin directly.
// - Switch bit 6 drops power at cycle end once an interrupt exists.
// - Setup register clears to zero at power-up.
// - Setup bit 7 resets whole device like power-on, then clears itself.
// - Setup bits 5:4 pick gain low, medium, high or maximum.
// - Setup bits 2:0 pick 100 ms steps, code 0 is 100 ms.
// - Results saturate at 37888 for 100 ms, else 65535.
// - Flags always reach status; pin only when matching allow bit set.
// - Unfiltered crossings flag at cycle end; filtered ones need persistence.
module lsec_ctrl
    import lsec_pkg::*;
#(
    parameter int MS_CYCLES = `LSEC_CLK_HZ / `LSEC_MS_PER_S
)(
    input  wire logic        sys_clk,
    input  wire logic        srst,
    input  wire logic [4:0]  reg_addr,
    input  wire logic        reg_wr,
    input  wire logic [7:0]  reg_wdata,
    output logic      [7:0]  reg_rdata,
    input  wire logic        persist_met,
    input  wire logic        np_cross,
    input  wire logic        light_flag,
    input  wire logic        np_flag,
    input  wire logic [16:0] ch0_raw,
    input  wire logic [16:0] ch1_raw,
    output lsec_cfg_t        cfg,
    output logic             cycle_end,
    output logic             light_flag_set,
    output logic             np_flag_set,
    output logic [15:0]      ch0_result,
    output logic [15:0]      ch1_result,
    output logic             irq_pin,
    output logic             device_reset
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------

    // Codes above 5 have no defined period, so they clamp to the longest
    function automatic logic [2:0] eff_period(input logic [2:0] code);
        eff_period = (code > `LSEC_TIME_MAX_CODE) ? `LSEC_TIME_MAX_CODE : code;
    endfunction

    // Shortest period tops out lower than the rest
    function automatic logic [15:0] sat_limit(input logic [2:0] code);
        sat_limit = (code == 3'h0) ? `LSEC_SAT_SHORT : `LSEC_SAT_LONG;
    endfunction

    function automatic logic [15:0] clamp(input logic [16:0] raw, input logic [15:0] lim);
        clamp = (raw > {1'b0, lim}) ? lim : raw[15:0];
    endfunction

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------

    logic [7:0]  switch_r;
    logic [7:0]  switch_nxt;
    logic [7:0]  setup_r;
    logic [7:0]  setup_nxt;
    logic        rst_pend_r;
    logic        rst_pend_nxt;
    logic        sleep_req;
    logic        soft_reset_hit;

    assign soft_reset_hit = reg_wr && (reg_addr == `LSEC_SETUP_OFS) && reg_wdata[`LSEC_SRST_BIT];

    // Register writes; reserved bits are dropped so they always read zero
    always_comb
    begin
        switch_nxt   = switch_r;
        setup_nxt    = setup_r;
        rst_pend_nxt = 1'b0;
        if (reg_wr && reg_addr == `LSEC_SWITCH_OFS)
        begin
            switch_nxt = reg_wdata & `LSEC_SWITCH_MASK;
        end
        if (reg_wr && reg_addr == `LSEC_SETUP_OFS)
        begin
            setup_nxt = reg_wdata & `LSEC_SETUP_MASK;
        end
        // Sleep only clears the oscillator bit, a host write in the same cycle loses
        if (sleep_req)
        begin
            switch_nxt[`LSEC_OSC_BIT] = 1'b0;
        end
        // Soft reset takes the next cycle; the bit itself is never stored
        if (soft_reset_hit)
        begin
            rst_pend_nxt = 1'b1;
        end
        if (rst_pend_r)
        begin
            switch_nxt = `LSEC_SWITCH_RST;
            setup_nxt  = `LSEC_SETUP_RST;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            switch_r   <= `LSEC_SWITCH_RST;
            setup_r    <= `LSEC_SETUP_RST;
            rst_pend_r <= 1'b0;
        end
        else
        begin
            switch_r   <= switch_nxt;
            setup_r    <= setup_nxt;
            rst_pend_r <= rst_pend_nxt;
        end
    end

    assign device_reset = rst_pend_r;

    // Read mux; unmapped offsets answer zero
    always_comb
    begin
        case (reg_addr)
            `LSEC_SWITCH_OFS: reg_rdata = switch_r;
            `LSEC_SETUP_OFS:  reg_rdata = setup_r;
            default:          reg_rdata = 8'h00;
        endcase
    end

    // ------------------------------------------------------------
    // Settings out
    // ------------------------------------------------------------

    always_comb
    begin
        cfg.osc_run  = switch_r[`LSEC_OSC_BIT];
        cfg.sense_on = switch_r[`LSEC_SENSE_BIT];
        cfg.gain     = setup_r[`LSEC_GAIN_HI:`LSEC_GAIN_LO];
        cfg.period   = eff_period(setup_r[`LSEC_TIME_HI:`LSEC_TIME_LO]);
    end

    // ------------------------------------------------------------
    // Integration timer
    // ------------------------------------------------------------

    localparam int MS_W = $clog2(MS_CYCLES + 1);

    lsec_state_t     state_r;
    lsec_state_t     state_nxt;
    logic [MS_W-1:0] tick_cnt_r;
    logic [MS_W-1:0] tick_cnt_nxt;
    logic [9:0]      ms_cnt_r;
    logic [9:0]      ms_cnt_nxt;
    logic            ms_tick;
    logic            running;
    logic [9:0]      period_ms;

    // Timer only advances while both the oscillator and the function are on
    assign running   = cfg.osc_run && cfg.sense_on && !rst_pend_r;
    assign ms_tick   = (tick_cnt_r == MS_W'(MS_CYCLES - 1));
    assign period_ms = 10'(({7'h00, cfg.period} + 10'h001) * `LSEC_STEP_MS);

    always_comb
    begin
        state_nxt    = state_r;
        tick_cnt_nxt = tick_cnt_r;
        ms_cnt_nxt   = ms_cnt_r;
        cycle_end    = 1'b0;
        case (state_r)
            LSEC_IDLE:
            begin
                tick_cnt_nxt = '0;
                ms_cnt_nxt   = '0;
                if (running)
                begin
                    state_nxt = LSEC_INTEGRATE;
                end
            end
            LSEC_INTEGRATE:
            begin
                if (!running)
                begin
                    state_nxt = LSEC_IDLE;
                end
                else
                begin
                    tick_cnt_nxt = ms_tick ? '0 : tick_cnt_r + 1'b1;
                    if (ms_tick)
                    begin
                        if (ms_cnt_r + 10'h001 >= period_ms)
                        begin
                            // Next cycle starts at once, as the converters do
                            ms_cnt_nxt = '0;
                            cycle_end  = 1'b1;
                        end
                        else
                        begin
                            ms_cnt_nxt = ms_cnt_r + 10'h001;
                        end
                    end
                end
            end
            default:
            begin
                state_nxt = LSEC_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            state_r    <= LSEC_IDLE;
            tick_cnt_r <= '0;
            ms_cnt_r   <= '0;
        end
        else
        begin
            state_r    <= state_nxt;
            tick_cnt_r <= tick_cnt_nxt;
            ms_cnt_r   <= ms_cnt_nxt;
        end
    end

    // ------------------------------------------------------------
    // Results, flags and pin
    // ------------------------------------------------------------

    logic [15:0] ch0_nxt;
    logic [15:0] ch1_nxt;

    // Results are captured and clamped only at the end of a cycle
    always_comb
    begin
        ch0_nxt = ch0_result;
        ch1_nxt = ch1_result;
        if (cycle_end)
        begin
            ch0_nxt = clamp(ch0_raw, sat_limit(cfg.period));
            ch1_nxt = clamp(ch1_raw, sat_limit(cfg.period));
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (srst || rst_pend_r)
        begin
            ch0_result <= 16'h0000;
            ch1_result <= 16'h0000;
        end
        else
        begin
            ch0_result <= ch0_nxt;
            ch1_result <= ch1_nxt;
        end
    end

    // Status flags set regardless of the allow bits; pin is gated
    assign np_flag_set    = cycle_end && np_cross;
    assign light_flag_set = cycle_end && persist_met;
    assign irq_pin        = (switch_r[`LSEC_LIRQ_BIT] && light_flag)
                          || (switch_r[`LSEC_NPIRQ_BIT] && np_flag);
    // Pending or just-raised interrupt counts toward sleep
    assign sleep_req      = cycle_end && switch_r[`LSEC_SLEEP_BIT]
                          && (light_flag || np_flag || np_flag_set || light_flag_set);

endmodule

// ### rtl/lsec_map.svh
`ifndef LSEC_MAP_SVH
`define LSEC_MAP_SVH
// Register offsets
`define LSEC_SWITCH_OFS    5'h00
`define LSEC_SETUP_OFS     5'h01
// Switch register fields
`define LSEC_OSC_BIT       0
`define LSEC_SENSE_BIT     1
`define LSEC_LIRQ_BIT      4
`define LSEC_SLEEP_BIT     6
`define LSEC_NPIRQ_BIT     7
`define LSEC_SWITCH_MASK   8'hD3
// Setup register fields
`define LSEC_SRST_BIT      7
`define LSEC_GAIN_HI       5
`define LSEC_GAIN_LO       4
`define LSEC_TIME_HI       2
`define LSEC_TIME_LO       0
`define LSEC_SETUP_MASK    8'h37
// Reset values
`define LSEC_SWITCH_RST    8'h00
`define LSEC_SETUP_RST     8'h00
// Timing
`define LSEC_CLK_HZ        20000000
`define LSEC_MS_PER_S      1000
`define LSEC_STEP_MS       100
`define LSEC_TIME_MAX_CODE 3'h5
// Saturation counts
`define LSEC_SAT_SHORT     16'h9400
`define LSEC_SAT_LONG      16'hFFFF
`endif

// ### rtl/lsec_pkg.sv
package lsec_pkg;
    // Settings that leave the register file for the converter front end
    typedef struct packed {
        logic       osc_run;
        logic       sense_on;
        logic [1:0] gain;
        logic [2:0] period;
    } lsec_cfg_t;

    typedef enum logic [1:0] {
        LSEC_GAIN_LOW,
        LSEC_GAIN_MED,
        LSEC_GAIN_HIGH,
        LSEC_GAIN_MAX
    } lsec_gain_t;

    typedef enum {
        LSEC_IDLE,
        LSEC_INTEGRATE
    } lsec_state_t;
endpackage

// ### sim/lsec_ctrl_assertions.sv
`timescale 1ns/10ps
module lsec_ctrl_assertions
    import lsec_pkg::*;
#(
    parameter int MS_CYCLES = 4
)(
    input wire logic        sys_clk,
    input wire logic        srst,
    input wire logic [4:0]  reg_addr,
    input wire logic        reg_wr,
    input wire logic [7:0]  reg_wdata,
    input wire logic [7:0]  reg_rdata,
    input wire logic        persist_met,
    input wire logic        np_cross,
    input wire logic        light_flag,
    input wire logic        np_flag,
    input wire logic [16:0] ch0_raw,
    input wire logic [16:0] ch1_raw,
    input wire lsec_cfg_t   cfg,
    input wire logic        cycle_end,
    input wire logic        light_flag_set,
    input wire logic        np_flag_set,
    input wire logic [15:0] ch0_result,
    input wire logic [15:0] ch1_result,
    input wire logic        irq_pin,
    input wire logic        device_reset
);
    localparam int T_LO = 100 * MS_CYCLES - 1;
    localparam int T_HI = 100 * MS_CYCLES + 1;
    // Sleep and soft reset beat a host write, so those cycles are left out below
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (srst);
    sequence s_soft_req;
        reg_wr && reg_addr == 5'h01 && reg_wdata[7];
    endsequence
    sequence s_soft_done;
        device_reset ##1 (!device_reset && cfg == 7'h00 && ch0_result == 16'h0000);
    endsequence
    chk_soft_reset: assert property (s_soft_req |=> s_soft_done)
        else $error("soft reset");
    chk_switch_write: assert property (reg_wr && reg_addr == 5'h00 && !cycle_end && !device_reset
        |=> {cfg.sense_on, cfg.osc_run} == $past(reg_wdata[1:0])) else $error("switch write");
    chk_setup_write: assert property (reg_wr && reg_addr == 5'h01 && !reg_wdata[7] && !device_reset
        |=> cfg.gain == $past(reg_wdata[5:4]) && cfg.period == (($past(reg_wdata[2])
        && $past(reg_wdata[1])) ? 3'h5 : $past(reg_wdata[2:0]))) else $error("setup write");
    chk_pin_gate: assert property (reg_addr == 5'h00 |-> irq_pin == ((reg_rdata[4] && light_flag)
        || (reg_rdata[7] && np_flag))) else $error("pin gating");
    chk_sleep_drop: assert property (cycle_end && reg_addr == 5'h00 && reg_rdata[6]
        && (light_flag || np_flag || light_flag_set || np_flag_set) |=> !cfg.osc_run) else $error("sleep");
    chk_result_clamp: assert property (cycle_end && !device_reset |=> ch0_result == ($past(cfg.period) == 3'h0
        ? ($past(ch0_raw) > 17'h09400 ? 16'h9400 : $past(ch0_raw[15:0]))
        : ($past(ch0_raw) > 17'h0FFFF ? 16'hFFFF : $past(ch0_raw[15:0])))) else $error("clamp");
    chk_flag_pulses: assert property (light_flag_set == (cycle_end && persist_met)
        && np_flag_set == (cycle_end && np_cross)) else $error("flag pulses");
    chk_first_period: assert property ($rose(cfg.osc_run && cfg.sense_on) && cfg.period == 3'h0
        |-> ##[T_LO:T_HI] cycle_end) else $error("period length");
endmodule
bind lsec_ctrl lsec_ctrl_assertions #(.MS_CYCLES(MS_CYCLES)) i_lsec_ctrl_assertions (.*);

// ### sim/lsec_flag_model.sv
`timescale 1ns/10ps
module lsec_flag_model (
    input  wire logic sys_clk,
    input  wire logic srst,
    input  wire logic light_flag_set,
    input  wire logic np_flag_set,
    input  wire logic flag_clr,
    output logic      light_flag,
    output logic      np_flag
);
    logic light_nxt;
    logic np_nxt;
    // Status flags latch whatever the allow bits say; only a clear command or srst drops them
    always_comb
    begin
        light_nxt = (light_flag | light_flag_set) & ~flag_clr;
        np_nxt = (np_flag | np_flag_set) & ~flag_clr;
    end
    // Registered so the pin sees the flag one cycle after the set pulse
    always_ff @(posedge sys_clk)
    begin
        light_flag <= srst ? 1'b0 : light_nxt;
        np_flag <= srst ? 1'b0 : np_nxt;
    end
endmodule

// ### sim/testbench.sv
`timescale 1ns/10ps
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin bad_count++; \
    $display("mismatch at %0t: %h vs %h", $time, got, exp); end end
module testbench;
    import lsec_pkg::*;
    logic        sys_clk = 1'b0;
    logic        srst = 1'b1;
    logic [4:0]  reg_addr = 5'h00;
    logic        reg_wr = 1'b0;
    logic [7:0]  reg_wdata = 8'h00;
    logic        persist_met = 1'b0;
    logic        np_cross = 1'b0;
    logic        flag_clr = 1'b0;
    logic [16:0] ch0_raw = 17'h00000;
    logic [16:0] ch1_raw = 17'h00000;
    logic [7:0]  reg_rdata;
    logic        light_flag, np_flag, cycle_end, light_flag_set, np_flag_set, irq_pin, device_reset;
    logic [15:0] ch0_result, ch1_result;
    lsec_cfg_t   cfg;
    int          bad_count = 0;
    int          comparisons = 0;
    // Rows: address, write data, read back, expected cfg, read back checked
    logic [28:0] rows [7] = '{{5'h00, 8'hF1, 8'hD1, 7'h40, 1'b1}, {5'h00, 8'h02, 8'h02, 7'h20, 1'b1},
        {5'h01, 8'h48, 8'h00, 7'h20, 1'b1}, {5'h01, 8'h11, 8'h11, 7'h29, 1'b1},
        {5'h01, 8'h22, 8'h22, 7'h32, 1'b1}, {5'h01, 8'h35, 8'h35, 7'h3D, 1'b1},
        {5'h01, 8'h06, 8'h00, 7'h25, 1'b0}};

    lsec_ctrl #(.MS_CYCLES(4)) i_lsec_ctrl (.*);
    lsec_flag_model i_lsec_flag_model (.*);

    // 20 MHz clock
    initial
    begin
        forever #25 sys_clk = ~sys_clk;
    end

    // Inputs move on the falling edge so the rising edge sees them settled
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge sys_clk);
        reg_wr = 1'b0;
    endtask

    // Bounded wait; a period 1 cycle is 800 clocks here
    task automatic wait_end();
        int n;
        n = 0;
        while (cycle_end !== 1'b1 && n < 2000)
        begin
            @(negedge sys_clk);
            n++;
        end
        if (n == 2000)
        begin
            bad_count++;
            $display("mismatch at %0t: no cycle end", $time);
        end
    endtask

    task automatic report_and_stop();
        $display("comparisons %0d, bad_count %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Whole run is about 2030 clocks
    initial
    begin
        repeat (6000) @(posedge sys_clk);
        bad_count++;
        report_and_stop();
    end

    initial
    begin
        repeat (8) @(negedge sys_clk);
        srst = 1'b0;
        wr(5'h02, 8'hFF);
        `CHK(reg_rdata, 8'h00)
        `CHK(cfg, 7'h00)
        foreach (rows[i])
        begin
            wr(rows[i][28:24], rows[i][23:16]);
            if (rows[i][0])
                `CHK(reg_rdata, rows[i][15:8])
            `CHK(cfg, rows[i][7:1])
        end
        // Soft reset pulses once, then the setup register reads zero and cfg clears
        wr(5'h00, 8'h01);
        wr(5'h01, 8'hB5);
        `CHK(device_reset, 1'b1)
        @(negedge sys_clk);
        `CHK({device_reset, reg_rdata}, 9'h000)
        `CHK(cfg, 7'h00)
        // Over-range raw counts clamp; flags reach the pin only through allow bits
        ch0_raw = 17'h1FFFF;
        ch1_raw = 17'h003E8;
        persist_met = 1'b1;
        np_cross = 1'b1;
        wr(5'h00, 8'h13);
        wait_end();
        `CHK({light_flag_set, np_flag_set}, 2'b11)
        @(negedge sys_clk);
        `CHK({ch0_result, ch1_result}, 32'h940003E8)
        `CHK(irq_pin, 1'b1)
        flag_clr = 1'b1;
        persist_met = 1'b0;
        ch0_raw = 17'h10000;
        @(negedge sys_clk);
        flag_clr = 1'b0;
        `CHK(irq_pin, 1'b0)
        wr(5'h01, 8'h01);
        wait_end();
        @(negedge sys_clk);
        `CHK(ch0_result, 16'hFFFF)
        wr(5'h00, 8'h03);
        `CHK({np_flag, irq_pin}, 2'b10)
        wr(5'h00, 8'h83);
        `CHK(irq_pin, 1'b1)
        // Sleep after interrupt drops the oscillator at the end of the cycle
        wr(5'h00, 8'h43);
        wait_end();
        @(negedge sys_clk);
        `CHK(reg_rdata, 8'h42)
        // A second reset mid-run must clear the setup register and the held ch0 result
        srst = 1'b1;
        reg_addr = 5'h01;
        repeat (2) @(negedge sys_clk);
        srst = 1'b0;
        `CHK({reg_rdata, ch0_result, cfg}, 31'h00000000)
        report_and_stop();
    end
endmodule
